/* File: touch_seq_pkg.sv */
// shared constants, encodings and types of the touch scan sequencer
package touch_seq_pkg;
  // ------------------------------------------------------------
  // converter function field codes
  // ------------------------------------------------------------
  localparam logic [3:0] FN_X        = 4'h2;
  localparam logic [3:0] FN_Y        = 4'h3;
  localparam logic [3:0] FN_Z        = 4'h4;
  localparam logic [3:0] FN_AUX      = 4'h5;
  localparam logic [3:0] FN_TEMP_A   = 4'h6;
  localparam logic [3:0] FN_TEMP_B   = 4'h7;
  localparam logic [3:0] FN_AUX_CONT = 4'h8;
  // ------------------------------------------------------------
  // command byte layout and driver codes
  // ------------------------------------------------------------
  localparam int         CMD_BITS    = 8;
  localparam int         CMD_CONV_BIT = 7;
  localparam int         CMD_FN_LSB  = 3;
  localparam logic [1:0] DRV_OFF     = 2'h0;
  localparam logic [1:0] DRV_X       = 2'h1;
  localparam logic [1:0] DRV_Y       = 2'h2;
  localparam logic [1:0] DRV_Z       = 2'h3;
  // ------------------------------------------------------------
  // pin function select: 00 pen and data, 10 pen only, else data only
  // ------------------------------------------------------------
  localparam logic [1:0] PIN_BOTH    = 2'h0;
  localparam logic [1:0] PIN_PEN     = 2'h2;
  // ------------------------------------------------------------
  // timing in oscillator cycles; start overheads kept in half cycles
  // ------------------------------------------------------------
  localparam int XY_START_OVH_HALF   = 5;
  localparam int Z_START_OVH_HALF    = 7;
  localparam int AUX_START_OVH_HALF  = 7;
  localparam int XY_START_CYC        = (XY_START_OVH_HALF + 1) / 2;
  localparam int Z_START_CYC         = (Z_START_OVH_HALF + 1) / 2;
  localparam int AUX_START_CYC       = (AUX_START_OVH_HALF + 1) / 2;
  localparam int SETTLE_OVH_SHORT    = 6;
  localparam int SETTLE_OVH_FULL     = 10;
  localparam int CONV_OVH_CYC        = 3;
  localparam int RES_EXTRA_CLK       = 2;
  localparam int RES_HI_BITS         = 12;
  localparam int RES_LO_BITS         = 10;
  localparam int TMR_W               = 16;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_START = 7'h02,
    S_STAB  = 7'h04,
    S_SENSE = 7'h08,
    S_CONV  = 7'h10,
    S_PPRO  = 7'h20,
    S_DONE  = 7'h40
  } seq_state_t;
  typedef enum logic [2:0] {
    K_NONE, K_X, K_Y, K_Z, K_AUX, K_AUX_CONT, K_TEMP_A, K_TEMP_B
  } meas_kind_t;
endpackage

/* File: tmr_if.sv */
// carrier between the sequencer and its interval timer
`timescale 1ns/1ps
interface tmr_if;
  logic                   load;
  logic [15:0]            value;
  logic                   done;
  modport ctrl (output load, output value, input done);
  modport tmr  (input load, input value, output done);
endinterface

/* File: cycle_timer.sv */
// interval timer: a load of n keeps it running for n cycles
`timescale 1ns/1ps
module cycle_timer (
  input  wire logic clk,
  input  wire logic srst,
  tmr_if.tmr        t
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // ------------------------------------------------------------
  // down counter
  // ------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    if (t.load) begin
      cnt_d = t.value;
    end else if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // last cycle of the interval
  assign t.done = (cnt_q == 16'h0001);
endmodule

/* File: link_cmd_rx.sv */
// serial command receiver on the host's link clock
`timescale 1ns/1ps
module link_cmd_rx (
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic [7:0]      byte_q,
  output logic            vld_q
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [6:0] sh_q;
  logic [6:0] sh_d;
  logic       vld_d;

  // ------------------------------------------------------------
  // msb first, one command byte per select frame
  // ------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    sh_d  = sh_q;
    vld_d = vld_q;
    if (!vld_q) begin
      cnt_d = cnt_q + 3'h1;
      sh_d  = {sh_q[5:0], mosi};
      if (cnt_q == 3'h7) begin
        vld_d = 1'b1;
      end
    end
  end

  // the link clock stops between frames, so deselect clears the frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 3'h0;
      sh_q  <= 7'h00;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      vld_q <= vld_d;
    end
  end

  // held until the next frame; read only after vld_q crosses over
  always_ff @(posedge sclk) begin
    if (!cs_n && !vld_q && cnt_q == 3'h7) begin
      byte_q <= {sh_q, mosi};
    end
  end
endmodule

/* File: touch_scan_sequencer.sv */
// host-controlled touch, auxiliary and temperature conversion sequencer
`timescale 1ns/1ps
// Function
// (RULE1) touch in host mode raises pen touch and pulls the pin low if pen function
// (RULE2) host sequences each step; no automatic multi-coordinate scan here
// (RULE3) host normally turns X drivers on first after the pen interrupt
// (RULE4) host waits settling time, then sends a separate X conversion command
// (RULE5) coordinate request with drivers off makes the device turn them on itself
// (RULE6) host repeats driver, settle, convert steps for Y and for Z
// (RULE7) with drivers already on, precharge and sense overhead is 6 cycles
// (RULE8) order: start overhead, precharge and sense, N conversions, preprocess latency
// (RULE9) drivers off before command: insert panel stabilization and larger overhead
// (RULE10) function code 0101 starts one auxiliary input measurement
// (RULE11) function code 1000 selects continuous auxiliary measurement
// (RULE12) codes 0110 and 0111 select the two temperature measurements
// (RULE13) temperature measurements use the single auxiliary timing
// (RULE14) auxiliary and temperature: 3.5 cycle start, no stabilize, precharge, sense
// (RULE15) X or Y start overhead is 2.5 oscillator cycles
// (RULE16) Z start overhead is 3.5 oscillator cycles
// (RULE17) every conversion carries 3 cycles of overhead
// (RULE18) with stabilization the combined overhead is 10 cycles
// (RULE19) continuous auxiliary restarts until another function is chosen
// (RULE20) each finished conversion stores its result and flags data available
module touch_scan_sequencer #(
  parameter int PVS_CYC   = 8,
  parameter int PRE_CYC   = 4,
  parameter int SNS_CYC   = 4,
  parameter int ADC_RATIO = 2
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        link_sclk,
  input  wire logic        link_cs_n,
  input  wire logic        link_mosi,
  input  wire logic        pen_touch_raw,
  input  wire logic [11:0] adc_sample,
  input  wire logic [1:0]  pin_function,
  input  wire logic        res_12bit,
  input  wire logic [4:0]  avg_count,
  input  wire logic [5:0]  preprocess_latency,
  output logic             pen_touch,
  output logic             pen_irq_data_avail_n,
  output logic [1:0]       panel_drivers,
  output logic [11:0]      result,
  output logic [3:0]       result_fn,
  output logic             busy
);
  import touch_seq_pkg::*;

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic meas_kind_t fn_kind(input logic [3:0] fn);
    unique case (fn)
      FN_X:        fn_kind = K_X;
      FN_Y:        fn_kind = K_Y;
      FN_Z:        fn_kind = K_Z;
      FN_AUX:      fn_kind = K_AUX;       // [RULE10]
      FN_AUX_CONT: fn_kind = K_AUX_CONT;  // [RULE11]
      FN_TEMP_A:   fn_kind = K_TEMP_A;    // [RULE12]
      FN_TEMP_B:   fn_kind = K_TEMP_B;    // [RULE12]
      default:     fn_kind = K_NONE;
    endcase
  endfunction

  function automatic logic [1:0] need_drv(input meas_kind_t k);
    unique case (k)
      K_X:     need_drv = DRV_X;
      K_Y:     need_drv = DRV_Y;
      K_Z:     need_drv = DRV_Z;
      default: need_drv = DRV_OFF;
    endcase
  endfunction

  function automatic logic [15:0] start_cyc(input meas_kind_t k);
    unique case (k)
      K_X, K_Y: start_cyc = 16'(XY_START_CYC);   // [RULE15]
      K_Z:      start_cyc = 16'(Z_START_CYC);    // [RULE16]
      default:  start_cyc = 16'(AUX_START_CYC);  // [RULE14] [RULE13]
    endcase
  endfunction

  // ------------------------------------------------------------
  // link receiver and crossings
  // ------------------------------------------------------------
  logic [7:0]  rx_byte;
  logic        rx_vld;
  logic [1:0]  vld_sync_q;
  logic        vld_seen_q;
  logic [1:0]  pen_sync_q;
  logic [11:0] smp_s1_q;
  logic [11:0] smp_s2_q;
  logic        cmd_pulse;

  link_cmd_rx u_rx (
    .sclk   (link_sclk),
    .cs_n   (link_cs_n),
    .mosi   (link_mosi),
    .byte_q (rx_byte),
    .vld_q  (rx_vld)
  );

  // sample is assumed held steady by the converter while it is read
  always_ff @(posedge clk) begin
    if (srst) begin
      vld_sync_q <= 2'h0;
      vld_seen_q <= 1'b0;
      pen_sync_q <= 2'h0;
      smp_s1_q   <= 12'h000;
      smp_s2_q   <= 12'h000;
    end else begin
      vld_sync_q <= {vld_sync_q[0], rx_vld};
      vld_seen_q <= vld_sync_q[1];
      pen_sync_q <= {pen_sync_q[0], pen_touch_raw};
      smp_s1_q   <= adc_sample;
      smp_s2_q   <= smp_s1_q;
    end
  end

  assign cmd_pulse = vld_sync_q[1] & ~vld_seen_q;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  tmr_if t ();
  cycle_timer u_tmr (
    .clk  (clk),
    .srst (srst),
    .t    (t.tmr)
  );

  seq_state_t  st_q, st_d;
  meas_kind_t  kind_q, kind_d;
  logic [3:0]  fn_q, fn_d;
  logic [1:0]  drv_q, drv_d;
  logic        stab_q, stab_d;
  logic [4:0]  left_q, left_d;
  logic [11:0] last_q, last_d;
  logic [11:0] res_q, res_d;
  logic [3:0]  rfn_q, rfn_d;
  logic        dav_q, dav_d;
  logic        pin_n_q, pin_n_d;
  logic        start_cmd;
  meas_kind_t  cmd_kind;
  logic [15:0] conv_cyc;
  logic [15:0] ppro_cyc;
  logic [4:0]  n_conv;
  logic        pen_fn;
  logic        dav_fn;
  logic        coord;

  assign cmd_kind  = fn_kind(rx_byte[CMD_FN_LSB +: 4]);
  assign start_cmd = cmd_pulse & rx_byte[CMD_CONV_BIT] & (cmd_kind != K_NONE);
  assign conv_cyc  = 16'(((res_12bit ? RES_HI_BITS : RES_LO_BITS) + RES_EXTRA_CLK) * ADC_RATIO
                         + CONV_OVH_CYC);  // [RULE8] [RULE17]
  assign ppro_cyc  = (preprocess_latency == 6'h00) ? 16'h0001 : {10'h000, preprocess_latency};
  assign n_conv    = (avg_count == 5'h00) ? 5'h01 : avg_count;
  assign coord     = (kind_q == K_X) || (kind_q == K_Y) || (kind_q == K_Z);
  assign pen_fn    = (pin_function == PIN_BOTH) || (pin_function == PIN_PEN);
  assign dav_fn    = (pin_function != PIN_PEN);

  always_comb begin
    st_d    = st_q;
    kind_d  = kind_q;
    fn_d    = fn_q;
    drv_d   = drv_q;
    stab_d  = stab_q;
    left_d  = left_q;
    last_d  = last_q;
    res_d   = res_q;
    rfn_d   = rfn_q;
    t.load  = 1'b0;
    t.value = 16'h0001;
    if (cmd_pulse && !rx_byte[CMD_CONV_BIT] && st_q == S_IDLE) begin
      drv_d = rx_byte[1:0];
    end
    unique case (st_q)
      S_IDLE: begin
      end
      S_START: begin
        if (t.done) begin
          t.load = 1'b1;
          if (!coord) begin
            st_d    = S_CONV;  // [RULE14]
            left_d  = n_conv;
            t.value = conv_cyc;
          end else if (drv_q != need_drv(kind_q)) begin
            drv_d   = need_drv(kind_q);  // [RULE5]
            stab_d  = 1'b1;
            st_d    = S_STAB;  // [RULE9]
            t.value = 16'(PVS_CYC);
          end else begin
            st_d    = S_SENSE;
            t.value = 16'(PRE_CYC + SNS_CYC + SETTLE_OVH_SHORT);  // [RULE7]
          end
        end
      end
      S_STAB: begin
        if (t.done) begin
          st_d    = S_SENSE;
          t.load  = 1'b1;
          t.value = 16'(PRE_CYC + SNS_CYC + SETTLE_OVH_FULL);  // [RULE18] [RULE9]
        end
      end
      S_SENSE: begin
        if (t.done) begin
          st_d    = S_CONV;  // [RULE8]
          left_d  = n_conv;
          t.load  = 1'b1;
          t.value = conv_cyc;
        end
      end
      S_CONV: begin
        if (t.done) begin
          last_d = smp_s2_q;
          t.load = 1'b1;
          if (left_q > 5'h01) begin
            left_d  = left_q - 5'h01;
            t.value = conv_cyc;
          end else begin
            st_d    = S_PPRO;  // [RULE8]
            t.value = ppro_cyc;
          end
        end
      end
      S_PPRO: begin
        if (t.done) begin
          st_d = S_DONE;
        end
      end
      S_DONE: begin
        res_d = res_12bit ? last_q : {2'h0, last_q[11:2]};  // [RULE20]
        rfn_d = fn_q;
        if (kind_q == K_AUX_CONT) begin
          st_d    = S_START;  // [RULE19]
          t.load  = 1'b1;
          t.value = start_cyc(kind_q);
        end else begin
          st_d = S_IDLE;  // [RULE2]
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    // a new function aborts whatever runs, continuous auxiliary included
    if (start_cmd) begin
      st_d    = S_START;
      kind_d  = cmd_kind;
      fn_d    = rx_byte[CMD_FN_LSB +: 4];
      stab_d  = 1'b0;
      t.load  = 1'b1;
      t.value = start_cyc(cmd_kind);
    end
  end

  // data-available: completion wins over the clear by a new command
  assign dav_d   = (dav_q & ~start_cmd) | (st_q == S_DONE);  // [RULE20]
  assign pin_n_d = ~((pen_fn & pen_sync_q[1]) | (dav_fn & dav_q));  // [RULE1]

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q    <= S_IDLE;
      kind_q  <= K_NONE;
      fn_q    <= 4'h0;
      drv_q   <= DRV_OFF;
      stab_q  <= 1'b0;
      left_q  <= 5'h00;
      last_q  <= 12'h000;
      res_q   <= 12'h000;
      rfn_q   <= 4'h0;
      dav_q   <= 1'b0;
      pin_n_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      kind_q  <= kind_d;
      fn_q    <= fn_d;
      drv_q   <= drv_d;
      stab_q  <= stab_d;
      left_q  <= left_d;
      last_q  <= last_d;
      res_q   <= res_d;
      rfn_q   <= rfn_d;
      dav_q   <= dav_d;
      pin_n_q <= pin_n_d;
    end
  end

  assign pen_touch            = pen_sync_q[1];  // [RULE1]
  assign pen_irq_data_avail_n = pin_n_q;
  assign panel_drivers        = drv_q;
  assign result               = res_q;
  assign result_fn            = rfn_q;
  assign busy                 = (st_q != S_IDLE);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [15:0] sense_len_q;
  always_ff @(posedge clk) begin
    if (srst || st_q != S_SENSE) begin
      sense_len_q <= 16'h0000;
    end else begin
      sense_len_q <= sense_len_q + 16'h0001;
    end
  end

  pen_pin_low_a: assert property (@(posedge clk) disable iff (srst)  // [RULE1]
    pen_sync_q[1] && pen_fn |=> !pen_irq_data_avail_n)
    else $error("pen touch did not pull the pin low");

  xy_start_len_a: assert property (@(posedge clk) disable iff (srst || cmd_pulse)  // [RULE15]
    $rose(st_q == S_START) && (kind_q == K_X || kind_q == K_Y)
      |-> (st_q == S_START) [*3] ##1 (st_q != S_START))
    else $error("xy start overhead length wrong");

  z_start_len_a: assert property (@(posedge clk) disable iff (srst || cmd_pulse)  // [RULE16]
    $rose(st_q == S_START) && kind_q == K_Z |-> (st_q == S_START) [*4] ##1 (st_q != S_START))
    else $error("z start overhead length wrong");

  aux_start_len_a: assert property (@(posedge clk) disable iff (srst || cmd_pulse)  // [RULE14]
    $rose(st_q == S_START) && !coord |-> (st_q == S_START) [*4] ##1 (st_q == S_CONV))
    else $error("aux start overhead or path wrong");

  sense_len_a: assert property (@(posedge clk) disable iff (srst)  // [RULE7]
    st_q == S_SENSE && st_d == S_CONV
      |-> sense_len_q + 16'h0001 == 16'(PRE_CYC + SNS_CYC + (stab_q ? SETTLE_OVH_FULL : SETTLE_OVH_SHORT)))
    else $error("precharge and sense interval length wrong");

  auto_drive_a: assert property (@(posedge clk) disable iff (srst || cmd_pulse)  // [RULE5]
    st_q == S_START && t.done && coord && drv_q != need_drv(kind_q)
      |=> st_q == S_STAB && drv_q == need_drv(kind_q) ##[1:1000] st_q == S_SENSE)
    else $error("drivers not switched on before the scan");

  no_panel_aux_a: assert property (@(posedge clk) disable iff (srst)  // [RULE14]
    (st_q == S_STAB || st_q == S_SENSE) |-> coord)
    else $error("panel interval used for a non-coordinate measurement");

  dav_flag_a: assert property (@(posedge clk) disable iff (srst)  // [RULE20]
    st_q == S_DONE && dav_fn |=> dav_q ##1 !pen_irq_data_avail_n)
    else $error("data available not flagged after a conversion");

  cont_restart_a: assert property (@(posedge clk) disable iff (srst)  // [RULE19]
    st_q == S_DONE && kind_q == K_AUX_CONT && !start_cmd |=> st_q == S_START && fn_q == FN_AUX_CONT)
    else $error("continuous auxiliary did not restart");
endmodule

/* File: host_link_model.sv */
// host side of the command link: one byte per select frame
`timescale 1ns/1ps
module host_link_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // --------------------------------
  // idle levels
  // --------------------------------
  initial begin
    sclk = 1'b0;
    mosi = 1'b1;
    // select rises after time zero so the receiver surely sees its clear
    #1 cs_n = 1'b1;
  end
  // --------------------------------
  // frame, msb first; clock still between frames
  // --------------------------------
  task automatic send_byte(input logic [7:0] b);
    #37;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    // select held past the decode window
    #40;
    cs_n = 1'b1;
    // deselected data shows no stale bit
    mosi = ~mosi;
    #100;
  endtask
endmodule

/* File: touch_scan_sequencer_tb.sv */
// self-checking bench of the touch scan sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); \
  end \
end
module touch_scan_sequencer_tb;
  import touch_seq_pkg::*;
  // --------------------------------
  // setup
  // --------------------------------
  localparam int PVS = 8;
  localparam int PRE = 4;
  localparam int SNS = 4;
  localparam int RAT = 2;
  logic        clk, srst, sclk, cs_n, mosi, raw, r12, pen, pin_n, busy;
  logic [11:0] adc, res;
  logic [1:0]  pfn, drv;
  logic [4:0]  navg;
  logic [5:0]  lat;
  logic [3:0]  rfn;
  int          n_errors, total_checks, bcnt;
  touch_scan_sequencer #(.PVS_CYC(PVS), .PRE_CYC(PRE), .SNS_CYC(SNS), .ADC_RATIO(RAT)) dut (
    .clk(clk), .srst(srst), .link_sclk(sclk), .link_cs_n(cs_n), .link_mosi(mosi),
    .pen_touch_raw(raw), .adc_sample(adc), .pin_function(pfn), .res_12bit(r12),
    .avg_count(navg), .preprocess_latency(lat), .pen_touch(pen),
    .pen_irq_data_avail_n(pin_n), .panel_drivers(drv), .result(res), .result_fn(rfn), .busy(busy));
  host_link_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // busy length counted in whole oscillator cycles
  always @(posedge clk) if (busy === 1'b1) bcnt <= bcnt + 1;
  // --------------------------------
  // helpers
  // --------------------------------
  function automatic int conv_len(input int start, input int pre);
    int b;
    b = r12 ? RES_HI_BITS : RES_LO_BITS;
    return start + pre + navg * ((b + RES_EXTRA_CLK) * RAT + CONV_OVH_CYC) + lat + 1;
  endfunction
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) n_errors++;
  endtask
  task automatic run(input logic [3:0] fn, input int exp_len);
    bcnt = 0;
    host.send_byte({1'b1, fn, 3'h0});
    wait_idle();
    `CHK("busy cycles", exp_len, bcnt)
    `CHK("result fn", fn, rfn)
  endtask
  task automatic drivers(input logic [1:0] d);
    host.send_byte({6'h00, d});
    repeat (4) @(negedge clk);
    `CHK("drivers", d, drv)
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_pen();
    pfn = PIN_PEN;
    raw = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("pen touch", 1'b1, pen)
    `CHK("pin pen", 1'b0, pin_n)
    pfn = 2'h1;
    repeat (2) @(negedge clk);
    `CHK("pin data only", 1'b1, pin_n)
    raw = 1'b0;
    pfn = PIN_BOTH;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_x_off();
    adc = 12'hA5C;
    run(FN_X, conv_len(XY_START_CYC, PVS + PRE + SNS + SETTLE_OVH_FULL));
    `CHK("drivers auto", DRV_X, drv)
    `CHK("x result", 12'hA5C, res)
    repeat (2) @(negedge clk);
    `CHK("data avail", 1'b0, pin_n)
  endtask
  task automatic t_y_on();
    drivers(DRV_Y);
    repeat (PVS) @(negedge clk);
    adc = 12'h3C1;
    run(FN_Y, conv_len(XY_START_CYC, PRE + SNS + SETTLE_OVH_SHORT));
    `CHK("y result", 12'h3C1, res)
  endtask
  task automatic t_z();
    drivers(DRV_Z);
    r12 = 1'b0;
    navg = 5'h02;
    adc = 12'hB6D;
    run(FN_Z, conv_len(Z_START_CYC, PRE + SNS + SETTLE_OVH_SHORT));
    `CHK("z 10-bit result", 12'h2DB, res)
    r12 = 1'b1;
    navg = 5'h01;
  endtask
  task automatic t_aux();
    logic [3:0] fns [3];
    fns = '{FN_AUX, FN_TEMP_A, FN_TEMP_B};
    foreach (fns[i]) begin
      adc = 12'h100 + 12'(i);
      run(fns[i], conv_len(AUX_START_CYC, 0));
      `CHK("aux result", 12'h100 + 12'(i), res)
    end
  endtask
  task automatic t_cont();
    adc = 12'h111;
    host.send_byte({1'b1, FN_AUX_CONT, 3'h0});
    `CHK("pin cleared", 1'b1, pin_n)
    repeat (100) @(negedge clk);
    adc = 12'h222;
    repeat (100) @(negedge clk);
    `CHK("cont busy", 1'b1, busy)
    `CHK("cont fn", FN_AUX_CONT, rfn)
    `CHK("cont result", 12'h222, res)
    host.send_byte({1'b1, FN_AUX, 3'h0});
    wait_idle();
    `CHK("stop fn", FN_AUX, rfn)
    repeat (100) @(negedge clk);
    `CHK("stays idle", 1'b0, busy)
  endtask
  // --------------------------------
  // run control
  // --------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
  initial begin
    srst = 1'b1;
    raw = 1'b0;
    adc = 12'h000;
    pfn = PIN_BOTH;
    r12 = 1'b1;
    navg = 5'h01;
    lat = 6'h02;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK("reset drivers", DRV_OFF, drv)
    `CHK("reset result", 12'h000, res)
    `CHK("reset pin", 1'b1, pin_n)
    t_pen();
    t_x_off();
    t_y_on();
    t_z();
    t_aux();
    t_cont();
    summarize();
  end
endmodule
